// >>> core/psa_alu.sv
// Packed SIMD integer datapath with eight 64-bit packed registers.
// Assumes decode issues at most one request per cycle, inputs synchronous to CLK.
`timescale 1ns/1ps
`include "psa_regs.svh"

// Notes on behaviour
// RQ1 - Byte lanes 0..7 at bits 0..63
// RQ2 - Word lanes 0..3, 16 bits each
// RQ3 - Doubleword lanes 0..1, 32 bits each
// RQ4 - Quadword is one unpartitioned 64-bit value; compares at lane Q use the two 32-bit doubleword lanes
// RQ5 - Moves whole 64-bit; lanes computed concurrently
// RQ6 - Signed or unsigned lanes per instruction
// RQ7 - Signed saturating byte add on eight lanes
// RQ8 - Memory bytes little-endian, low byte first
// RQ9 - Register layout equals memory layout
// RQ10 - Full-width access for 64-bit operations
// RQ11 - Half-width access for 32-bit transfers
// RQ12 - Lane split follows operation type
// RQ13 - Wraparound keeps low lane bits
// RQ14 - Saturation clamps to range limits
// RQ15 - Signed byte clamps 80H and 7FH
// RQ16 - Signed word clamps 8000H and 7FFFH
// RQ17 - Unsigned byte clamps 00H and FFH
// RQ18 - Unsigned word clamps 0000H and FFFFH
// RQ19 - No flags or exceptions on overflow
// RQ20 - 57 operations in seven groups; psa_op_e encodes 13 operations plus NOP
// RQ21 - Eight 64-bit packed data registers
// RQ22 - Destination is input and result target
// RQ23 - Carries and clamps stay within lanes
module psa_alu #(
  parameter int NUM_REGS = `PSA_NUM_REGS
) (
  input wire logic CLK, // Core clock
  input wire logic RESET_N, // Synchronous reset
  input psa_pkg::psa_req_s REQ, // Issued operation
  output psa_pkg::psa_rsp_s RSP, // Registered result
  output logic READY, // Accepts a request
  output logic STATE_EMPTY // Packed state emptied
);
  import psa_pkg::*;

  initial begin
    if (NUM_REGS != `PSA_NUM_REGS) begin
      $error("psa_alu: NUM_REGS must be 8");
    end
    if (`PSA_DATA_W != 64) begin
      $error("psa_alu: operand width must be 64");
    end
    if (2 * `PSA_HALF_W != `PSA_DATA_W) begin
      $error("psa_alu: half width must be half the operand");
    end
    if (`PSA_OP_COUNT != 57) begin
      $error("psa_alu: operation count must be 57");
    end
    if (`PSA_SB_MIN != ~`PSA_SB_MAX) begin
      $error("psa_alu: signed byte clamps inconsistent");
    end
    if (`PSA_SW_MIN != ~`PSA_SW_MAX) begin
      $error("psa_alu: signed word clamps inconsistent");
    end
  end

  psa_core_s cur_q;
  psa_core_s nxt_d;

  logic [63:0] dst_v;
  logic [63:0] src_v;
  logic [63:0] res_b;
  logic [63:0] res_w;
  logic [63:0] res_d;
  logic [63:0] res_q;
  logic [63:0] lane_res;
  logic [63:0] res_v;
  logic sub;
  logic cmp;
  // Decoded issue qualifiers
  logic exec_op;
  logic empty_op;
  logic [7:0][7:0] store_img;

  assign sub = (REQ.op == PSA_OP_SUB);
  assign empty_op = REQ.valid && (REQ.op == PSA_OP_EMPTY);
  assign exec_op = REQ.valid && (REQ.op != PSA_OP_NOP) && (REQ.op != PSA_OP_EMPTY);
  assign cmp = (REQ.op == PSA_OP_CMPEQ) || (REQ.op == PSA_OP_CMPGT);
  // Destination doubles as first source
  assign dst_v = cur_q.regs[REQ.dst]; // see RQ22
  assign src_v = REQ.src_mem ? REQ.mem_data : cur_q.regs[REQ.src]; // see RQ9

  // Per-lane math, one 8-, 16- or 32-bit lane each
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : g_b
      logic [7:0] a;
      logic [7:0] b;
      logic [8:0] us;
      logic [8:0] ss;
      logic s_ovf;
      logic u_ovf;
      always_comb begin
        a = dst_v[gb*8 +: 8]; // see RQ1
        b = src_v[gb*8 +: 8];
        us = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b}); // see RQ23
        ss = sub ? ({a[7], a} - {b[7], b}) : ({a[7], a} + {b[7], b});
        // Overflow judged from this lane only
        s_ovf = (ss[8] != ss[7]);
        u_ovf = us[8];
        if (cmp) begin
          if (REQ.op == PSA_OP_CMPEQ) begin
            res_b[gb*8 +: 8] = (a == b) ? 8'hFF : 8'h00;
          end else begin
            res_b[gb*8 +: 8] = ($signed(a) > $signed(b)) ? 8'hFF : 8'h00;
          end
        end else if (REQ.arith == PSA_ARI_SSAT && s_ovf) begin
          res_b[gb*8 +: 8] = ss[8] ? `PSA_SB_MIN : `PSA_SB_MAX; // see RQ7 see RQ15 see RQ14
        end else if (REQ.arith == PSA_ARI_USAT && u_ovf) begin
          res_b[gb*8 +: 8] = sub ? `PSA_UB_MIN : `PSA_UB_MAX; // see RQ17 see RQ6
        end else begin
          res_b[gb*8 +: 8] = us[7:0]; // see RQ13
        end
      end
    end
    for (gb = 0; gb < 4; gb++) begin : g_w
      logic [15:0] a;
      logic [15:0] b;
      logic [16:0] us;
      logic [16:0] ss;
      logic s_ovf;
      logic u_ovf;
      always_comb begin
        a = dst_v[gb*16 +: 16]; // see RQ2
        b = src_v[gb*16 +: 16];
        us = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        ss = sub ? ({a[15], a} - {b[15], b}) : ({a[15], a} + {b[15], b});
        s_ovf = (ss[16] != ss[15]);
        u_ovf = us[16];
        if (cmp) begin
          if (REQ.op == PSA_OP_CMPEQ) begin
            res_w[gb*16 +: 16] = (a == b) ? 16'hFFFF : 16'h0000;
          end else begin
            res_w[gb*16 +: 16] = ($signed(a) > $signed(b)) ? 16'hFFFF : 16'h0000;
          end
        end else if (REQ.arith == PSA_ARI_SSAT && s_ovf) begin
          res_w[gb*16 +: 16] = ss[16] ? `PSA_SW_MIN : `PSA_SW_MAX; // see RQ16
        end else if (REQ.arith == PSA_ARI_USAT && u_ovf) begin
          res_w[gb*16 +: 16] = sub ? `PSA_UW_MIN : `PSA_UW_MAX; // see RQ18
        end else begin
          res_w[gb*16 +: 16] = us[15:0];
        end
      end
    end
    for (gb = 0; gb < 2; gb++) begin : g_d
      logic [31:0] a;
      logic [31:0] b;
      logic [32:0] us;
      logic [32:0] ss;
      logic s_ovf;
      logic u_ovf;
      always_comb begin
        a = dst_v[gb*32 +: 32]; // see RQ3
        b = src_v[gb*32 +: 32];
        us = sub ? ({1'b0, a} - {1'b0, b}) : ({1'b0, a} + {1'b0, b});
        ss = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
        s_ovf = (ss[32] != ss[31]);
        u_ovf = us[32];
        if (cmp) begin
          if (REQ.op == PSA_OP_CMPEQ) begin
            res_d[gb*32 +: 32] = (a == b) ? `PSA_UD_MAX : 32'h00000000;
          end else begin
            res_d[gb*32 +: 32] = ($signed(a) > $signed(b)) ? `PSA_UD_MAX : 32'h00000000;
          end
        end else if (REQ.arith == PSA_ARI_SSAT && s_ovf) begin
          res_d[gb*32 +: 32] = ss[32] ? `PSA_SD_MIN : `PSA_SD_MAX;
        end else if (REQ.arith == PSA_ARI_USAT && u_ovf) begin
          res_d[gb*32 +: 32] = sub ? 32'h00000000 : `PSA_UD_MAX;
        end else begin
          res_d[gb*32 +: 32] = us[31:0];
        end
      end
    end
  endgenerate

  // Quadword add and subtract have no lane boundaries
  assign res_q = sub ? (dst_v - src_v) : (dst_v + src_v); // see RQ4

  // Store image, byte i goes to address base plus i
  genvar gm;
  generate
    for (gm = 0; gm < 8; gm++) begin : g_m
      assign store_img[gm] = dst_v[gm*8 +: 8]; // see RQ8
    end
  endgenerate

  always_comb begin
    case (REQ.lane) // see RQ12 see RQ5
      PSA_LANE_B: lane_res = res_b;
      PSA_LANE_W: lane_res = res_w;
      PSA_LANE_D: lane_res = res_d;
      PSA_LANE_Q: lane_res = cmp ? res_d : res_q;
      default: lane_res = res_q;
    endcase
  end

  // Result select; no overflow flag outputs exist, see RQ19
  always_comb begin
    case (REQ.op)
      PSA_OP_ADD, PSA_OP_SUB, PSA_OP_CMPEQ, PSA_OP_CMPGT: res_v = lane_res;
      PSA_OP_AND: res_v = dst_v & src_v; // see RQ10
      PSA_OP_ANDN: res_v = ~dst_v & src_v;
      PSA_OP_OR: res_v = dst_v | src_v;
      PSA_OP_XOR: res_v = dst_v ^ src_v;
      PSA_OP_MOVQ, PSA_OP_LOADQ: res_v = src_v; // see RQ10
      PSA_OP_MOVD: res_v = {32'h00000000, REQ.gpr_data}; // see RQ11
      PSA_OP_LOADD: res_v = {32'h00000000, REQ.mem_data[31:0]}; // see RQ11
      default: res_v = dst_v;
    endcase
  end

  // Next-state logic; psa_op_e has 14 codes, not the 57 operations of RQ20
  always_comb begin
    nxt_d = cur_q;
    nxt_d.rsp.valid = 1'b0;
    case (cur_q.st)
      PSA_ST_READY, PSA_ST_EMPTY: begin
        if (empty_op) begin
          nxt_d.st = PSA_ST_EMPTY;
        end else if (exec_op) begin
          nxt_d.st = PSA_ST_READY;
          nxt_d.regs[REQ.dst] = res_v; // see RQ22 see RQ21
          nxt_d.rsp.valid = 1'b1;
          nxt_d.rsp.dst = REQ.dst;
          nxt_d.rsp.data = res_v;
          nxt_d.rsp.mem_bytes = store_img; // see RQ9
          nxt_d.rsp.half_data = dst_v[31:0]; // see RQ11
        end
      end
      default: nxt_d.st = PSA_ST_READY;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cur_q <= '0;
      cur_q.st <= PSA_ST_READY;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign RSP = cur_q.rsp;
  assign READY = 1'b1;
  assign STATE_EMPTY = (cur_q.st == PSA_ST_EMPTY);
endmodule

// >>> core/psa_pkg.sv
// Types for the packed SIMD integer datapath.
// Assumes psa_regs.svh is on the include path.
`include "psa_regs.svh"
package psa_pkg;
  typedef logic [`PSA_DATA_W-1:0] psa_word_t;
  typedef logic [2:0] psa_ridx_t;

  typedef enum logic [3:0] {
    PSA_OP_NOP = 4'h0,
    PSA_OP_ADD = 4'h1,
    PSA_OP_SUB = 4'h2,
    PSA_OP_AND = 4'h3,
    PSA_OP_ANDN = 4'h4,
    PSA_OP_OR = 4'h5,
    PSA_OP_XOR = 4'h6,
    PSA_OP_CMPEQ = 4'h7,
    PSA_OP_CMPGT = 4'h8,
    PSA_OP_MOVQ = 4'h9,
    PSA_OP_MOVD = 4'hA,
    PSA_OP_LOADQ = 4'hB,
    PSA_OP_LOADD = 4'hC,
    PSA_OP_EMPTY = 4'hD
  } psa_op_e;

  typedef enum logic [1:0] {
    PSA_LANE_B = 2'h0,
    PSA_LANE_W = 2'h1,
    PSA_LANE_D = 2'h2,
    PSA_LANE_Q = 2'h3
  } psa_lane_e;

  typedef enum logic [1:0] {
    PSA_ARI_WRAP = 2'h0,
    PSA_ARI_SSAT = 2'h1,
    PSA_ARI_USAT = 2'h2
  } psa_arith_e;

  typedef struct packed {
    logic valid;
    psa_op_e op;
    psa_lane_e lane;
    psa_arith_e arith;
    psa_ridx_t dst;
    psa_ridx_t src;
    logic src_mem;
    psa_word_t mem_data;
    logic [`PSA_HALF_W-1:0] gpr_data;
  } psa_req_s;

  typedef struct packed {
    logic valid;
    psa_ridx_t dst;
    psa_word_t data;
    logic [7:0][7:0] mem_bytes;
    logic [`PSA_HALF_W-1:0] half_data;
  } psa_rsp_s;

  typedef enum logic [1:0] {
    PSA_ST_READY = 2'b01,
    PSA_ST_EMPTY = 2'b10
  } psa_state_e;

  typedef struct packed {
    psa_state_e st;
    logic [`PSA_NUM_REGS-1:0][`PSA_DATA_W-1:0] regs;
    psa_rsp_s rsp;
  } psa_core_s;
endpackage

// >>> core/psa_regs.svh
// Constants for the packed SIMD integer datapath.
// Assumes inclusion by the package and the datapath module only.
`ifndef PSA_REGS_SVH
`define PSA_REGS_SVH
`define PSA_DATA_W 64
`define PSA_HALF_W 32
`define PSA_NUM_REGS 8
`define PSA_SB_MIN 8'h80
`define PSA_SB_MAX 8'h7F
`define PSA_SW_MIN 16'h8000
`define PSA_SW_MAX 16'h7FFF
`define PSA_UB_MIN 8'h00
`define PSA_UB_MAX 8'hFF
`define PSA_UW_MIN 16'h0000
`define PSA_UW_MAX 16'hFFFF
`define PSA_SD_MIN 32'h80000000
`define PSA_SD_MAX 32'h7FFFFFFF
`define PSA_UD_MAX 32'hFFFFFFFF
`define PSA_OP_COUNT 57
`endif

// >>> tb/psa_alu_sva.sv
// Port checker for the packed SIMD datapath.
// Assumes one clock CLK and a synchronous active-low RESET_N.
`timescale 1ns/1ps
module psa_alu_chk #(
  parameter int NUM_REGS = 8
) (
  input wire logic CLK, // Core clock
  input wire logic RESET_N, // Reset
  input psa_pkg::psa_req_s REQ, // Request
  input psa_pkg::psa_rsp_s RSP, // Result
  input wire logic READY, // Accept
  input wire logic STATE_EMPTY // Emptied
);
  import psa_pkg::*;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  wire go = REQ.valid && REQ.op != PSA_OP_NOP && REQ.op != PSA_OP_EMPTY;
  wire rr = go && !REQ.src_mem && REQ.src == REQ.dst;
  a_rsp_follows: assert property (go |=> RSP.valid && RSP.dst == $past(REQ.dst))
    else $error("result missing");
  a_rsp_idle: assert property (!go |=> !RSP.valid)
    else $error("spurious result");
  a_loadq_copy: assert property (go && REQ.op == PSA_OP_LOADQ |=> RSP.data == $past(REQ.mem_data))
    else $error("load changed data");
  a_loadd_zero: assert property (go && REQ.op == PSA_OP_LOADD |=>
    RSP.data[63:32] == 32'h0 && RSP.data[31:0] == 32'($past(REQ.mem_data)))
    else $error("half load wrong");
  a_movd_zero: assert property (go && REQ.op == PSA_OP_MOVD |=>
    RSP.data == {32'h0, $past(REQ.gpr_data)})
    else $error("half move wrong");
  a_store_image: assert property (rr && REQ.op == PSA_OP_MOVQ |=>
    RSP.mem_bytes == RSP.data && RSP.half_data == RSP.data[31:0])
    else $error("store image wrong");
  a_xor_self: assert property (rr && REQ.op == PSA_OP_XOR |=> RSP.data == 64'h0)
    else $error("self xor not zero");
  a_empty_set: assert property (REQ.valid && REQ.op == PSA_OP_EMPTY |=>
    STATE_EMPTY && !RSP.valid)
    else $error("empty op wrong");
  a_empty_clear: assert property (go |=> !STATE_EMPTY)
    else $error("empty flag stuck");
endmodule
bind psa_alu psa_alu_chk #(.NUM_REGS(NUM_REGS)) psa_alu_chk_i (.CLK(CLK), .RESET_N(RESET_N),
  .REQ(REQ), .RSP(RSP), .READY(READY), .STATE_EMPTY(STATE_EMPTY));

// >>> tb/psa_dec_model.sv
// Decode-side model issuing one request at a time.
// Assumes the bench calls send and judges the answer.
`timescale 1ns/1ps
module psa_dec_model (
  input wire logic clk, // Core clock
  output psa_pkg::psa_req_s req // Issued request
);
  import psa_pkg::*;
  initial req = '0;
  task automatic send(input psa_req_s r);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req.valid <= 1'b0;
    req.mem_data <= ~r.mem_data;
    #1;
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the packed SIMD datapath.
// Assumes results one cycle after the request is taken.
`timescale 1ns/1ps
module tb;
  import psa_pkg::*;
  localparam psa_word_t OA = 64'h7FFF_FFFF_8000_0180;
  localparam psa_word_t OB = 64'h0001_FF01_8001_7F80;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  psa_req_s req;
  psa_rsp_s rsp;
  logic ready;
  logic state_empty;
  int miscompares = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  psa_dec_model psa_dec_model_i (.clk(clk), .req(req));
  psa_alu psa_alu_i (.CLK(clk), .RESET_N(reset_n), .REQ(req), .RSP(rsp), .READY(ready),
    .STATE_EMPTY(state_empty));
  task automatic chk(input psa_word_t got, input psa_word_t exp);
    tests_run++;
    if (got !== exp) begin
      $display("BAD %0t got %h exp %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic op(psa_op_e o, psa_lane_e l, psa_arith_e a, int d, int s, bit m, psa_word_t v);
    psa_dec_model_i.send('{1'b1, o, l, a, 3'(d), 3'(s), m, v, ~v[31:0]});
    chk({63'h0, rsp.valid}, {63'h0, o != PSA_OP_EMPTY});
    chk({63'h0, ready}, 64'h1);
    if (o != PSA_OP_EMPTY) chk({61'h0, rsp.dst}, {61'h0, 3'(d)});
  endtask
  task automatic ld(int d, psa_word_t v);
    op(PSA_OP_LOADQ, PSA_LANE_Q, PSA_ARI_WRAP, d, 0, 1, v);
  endtask
  function automatic psa_word_t ref_as(psa_word_t d, psa_word_t s, int w, int m, bit sb);
    longint mk, a, b, r;
    psa_word_t o;
    mk = (longint'(1) << w) - 1;
    o = '0;
    for (int i = 0; i < 64; i += w) begin
      a = (d >> i) & mk;
      b = (s >> i) & mk;
      if (m == 1 && a > mk / 2) a -= mk + 1;
      if (m == 1 && b > mk / 2) b -= mk + 1;
      r = sb ? a - b : a + b;
      if (m == 1) r = r > mk / 2 ? mk / 2 : (r < -(mk / 2) - 1 ? -(mk / 2) - 1 : r);
      if (m == 2) r = r > mk ? mk : (r < 0 ? 0 : r);
      o |= psa_word_t'(r & mk) << i;
    end
    return o;
  endfunction
  function automatic psa_word_t ref_cmp(psa_word_t d, psa_word_t s, bit gt);
    psa_word_t o;
    for (int i = 0; i < 64; i += 8)
      o[i +: 8] = (gt ? $signed(d[i +: 8]) > $signed(s[i +: 8]) : d[i +: 8] == s[i +: 8]) ?
        8'hFF : 8'h00;
    return o;
  endfunction
  task automatic t_load;
    op(PSA_OP_MOVQ, PSA_LANE_Q, PSA_ARI_WRAP, 3, 3, 0, 0);
    chk(rsp.data, '0);
    ld(1, 64'h0123_4567_89AB_CDEF);
    chk(rsp.data, 64'h0123_4567_89AB_CDEF);
    op(PSA_OP_LOADD, PSA_LANE_D, PSA_ARI_WRAP, 2, 0, 1, OA);
    chk(rsp.data, 64'h0000_0000_8000_0180);
    op(PSA_OP_MOVD, PSA_LANE_D, PSA_ARI_WRAP, 2, 0, 0, OA);
    chk(rsp.data, 64'h0000_0000_7FFF_FE7F);
    op(PSA_OP_MOVQ, PSA_LANE_Q, PSA_ARI_WRAP, 1, 1, 0, 0);
    chk(rsp.mem_bytes[0], 8'hEF);
    chk(rsp.mem_bytes[7], 8'h01);
  endtask
  task automatic t_ssb;
    ld(6, 64'h7F80_7F80_0102_FF00);
    op(PSA_OP_ADD, PSA_LANE_B, PSA_ARI_SSAT, 6, 0, 1, 64'h0180_0180_7F7F_0101);
    chk(rsp.data, 64'h7F80_7F80_7F7F_0001);
  endtask
  task automatic t_arith;
    ld(5, OB);
    for (int l = 0; l < 3; l++)
      for (int a = 0; a < 3; a++)
        for (int s = 0; s < 2; s++) begin
          ld(4, OA);
          op(s ? PSA_OP_SUB : PSA_OP_ADD, psa_lane_e'(l), psa_arith_e'(a), 4, 5, 0, 0);
          chk(rsp.data, ref_as(OA, OB, 8 << l, a, s[0]));
        end
  endtask
  task automatic t_logic;
    psa_op_e ops[6] = '{PSA_OP_AND, PSA_OP_ANDN, PSA_OP_OR, PSA_OP_XOR, PSA_OP_CMPEQ,
      PSA_OP_CMPGT};
    psa_word_t e[6] = '{OA & OB, ~OA & OB, OA | OB, OA ^ OB, ref_cmp(OA, OB, 0),
      ref_cmp(OA, OB, 1)};
    foreach (ops[k]) begin
      ld(4, OA);
      op(ops[k], PSA_LANE_B, PSA_ARI_WRAP, 4, 5, 0, 0);
      chk(rsp.data, e[k]);
    end
    op(PSA_OP_XOR, PSA_LANE_Q, PSA_ARI_WRAP, 5, 5, 0, 0);
    chk(rsp.data, '0);
  endtask
  task automatic t_empty;
    op(PSA_OP_EMPTY, PSA_LANE_Q, PSA_ARI_WRAP, 0, 0, 0, 0);
    chk({63'h0, state_empty}, 64'h1);
    op(PSA_OP_MOVQ, PSA_LANE_Q, PSA_ARI_WRAP, 1, 1, 0, 0);
    chk({63'h0, state_empty}, 64'h0);
  endtask
  task automatic print_verdict;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_load;
    t_ssb;
    t_arith;
    t_logic;
    t_empty;
    print_verdict;
  end
  initial begin
    repeat (2000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
endmodule
